// *** logic/bsl_loader.sv ***
// Serial boot loader: entry at reset, zero byte, ID answer, 32-byte load, run
// ------------------------------------------------------------
// Notes on behaviour
// [RULE_01] Boot select low when reset ends enters loader mode, else normal start.
// [RULE_02] Loader entry ignores the external bus configuration strapped at reset.
// [RULE_03] Loader lives in its own boot ROM, outside the 128 Kbyte flash.
// [RULE_04] In loader mode only listen on serial input until a zero byte.
// [RULE_05] After the zero byte send exactly one identification byte.
// [RULE_06] Then receive exactly 32 bytes into RAM FA40h to FA5Fh in order.
// [RULE_07] After the last byte, start executing at FA40h unprompted.
// [RULE_08] Host sends zero, checks the ID byte, then sends 32 bytes.
// [RULE_09] Host holds boot select low through reset before serial traffic.
// [RULE_10] Characters are 8N1, least significant bit first, agreed rate.
// ------------------------------------------------------------
module bsld_loader
    import bsld_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYCLES,
    parameter logic [7:0] ID_BYTE = 8'h3c // Arbitrary identification value
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic boot_select_pin,
    input wire logic [1:0] bus_config,
    input wire logic rxd,
    output logic txd,
    output logic serial_boot_loader_mode,
    output logic normal_start,
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic run_start,
    output logic [15:0] run_addr,
    output logic [15:0] fetch_base
);
    localparam int CW = $clog2(BIT_CYC + 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rx_s1, rx_s2, sel_s1, sel_s2;
    logic reset_d;

    // Two stages per pin; only the second stage is ever read
    always_ff @(posedge mclk) begin
        rx_s1 <= rxd;
        rx_s2 <= rx_s1;
        sel_s1 <= boot_select_pin;
        sel_s2 <= sel_s1;
        reset_d <= reset;
    end

    // ------------------------------------------------------------
    // Serial receiver, 8N1 sampled mid-bit
    // ------------------------------------------------------------
    logic rx_busy, next_rx_busy;
    logic [CW-1:0] rx_cnt, next_rx_cnt;
    logic [3:0] rx_bit, next_rx_bit;
    logic [7:0] rx_sh, next_rx_sh;
    logic rx_vld, next_rx_vld;

    // Start edge waits half a bit, then samples each bit centre
    always_comb begin
        next_rx_busy = rx_busy;
        next_rx_cnt = rx_cnt;
        next_rx_bit = rx_bit;
        next_rx_sh = rx_sh;
        next_rx_vld = 1'b0;
        if (!rx_busy) begin
            if (!rx_s2) begin
                next_rx_busy = 1'b1;
                next_rx_cnt = CW'(BIT_CYC / 2);
                next_rx_bit = 4'd0;
            end
        end else if (rx_cnt != '0) begin
            next_rx_cnt = rx_cnt - CW'(1);
        end else begin
            next_rx_cnt = CW'(BIT_CYC - 1);
            next_rx_bit = rx_bit + 4'd1;
            if (rx_bit == 4'd0 && rx_s2) begin
                next_rx_busy = 1'b0; // Glitch, not a start bit
            end else if (rx_bit >= 4'd1 && rx_bit <= 4'd8) begin
                next_rx_sh = {rx_s2, rx_sh[7:1]}; // see [RULE_10]
            end else if (rx_bit == 4'd9) begin
                next_rx_busy = 1'b0;
                next_rx_vld = rx_s2; // Framing error drops the byte
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_busy <= 1'b0;
            rx_cnt <= '0;
            rx_bit <= 4'd0;
            rx_sh <= SHIFT_RESET;
            rx_vld <= 1'b0;
        end else begin
            rx_busy <= next_rx_busy;
            rx_cnt <= next_rx_cnt;
            rx_bit <= next_rx_bit;
            rx_sh <= next_rx_sh;
            rx_vld <= next_rx_vld;
        end
    end

    // ------------------------------------------------------------
    // Loader sequence
    // ------------------------------------------------------------
    bsld_state_t state, next_state;
    logic [5:0] load_cnt, next_load_cnt;
    logic next_mode, next_normal, next_we, next_run;
    logic [15:0] next_addr, next_run_addr, next_fetch;
    logic [7:0] next_wdata;
    logic tx_start, tx_busy, tx_busy_d;

    // Strap caught by a clocked process on the first cycle after reset
    always_comb begin
        next_state = state;
        next_load_cnt = load_cnt;
        next_mode = serial_boot_loader_mode;
        next_normal = normal_start;
        next_we = 1'b0;
        next_run = 1'b0;
        next_addr = ram_addr;
        next_wdata = ram_wdata;
        next_run_addr = run_addr;
        next_fetch = fetch_base;
        tx_start = 1'b0;
        case (state)
            ST_IDLE: begin
                if (reset_d) begin
                    // Bus configuration deliberately not consulted
                    if (!sel_s2) begin // see [RULE_01] see [RULE_02]
                        next_state = ST_WAIT_ZERO;
                        next_mode = 1'b1;
                        next_fetch = BOOT_ROM_BASE; // see [RULE_03]
                    end else begin
                        next_state = ST_NORMAL;
                        next_normal = 1'b1;
                    end
                end
            end
            ST_WAIT_ZERO: begin
                // Nonzero bytes are simply discarded
                if (rx_vld && rx_sh == ZERO_BYTE) begin // see [RULE_04]
                    next_state = ST_SEND_ID;
                end
            end
            ST_SEND_ID: begin
                tx_start = 1'b1; // see [RULE_05]
                next_state = ST_WAIT_ID;
            end
            ST_WAIT_ID: begin
                if (tx_busy_d && !tx_busy) begin
                    next_state = ST_LOAD;
                    next_load_cnt = 6'd0;
                    next_addr = RAM_WIN_START;
                end
            end
            ST_LOAD: begin
                if (rx_vld) begin
                    next_we = 1'b1; // see [RULE_06]
                    next_wdata = rx_sh;
                    next_addr = RAM_WIN_START + {10'h000, load_cnt};
                    next_load_cnt = load_cnt + 6'd1;
                    if (load_cnt == 6'(LOAD_BYTES - 1)) begin
                        next_state = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                next_run = 1'b1; // see [RULE_07]
                next_run_addr = RAM_WIN_START;
                next_fetch = RAM_WIN_START;
                next_mode = 1'b0;
                next_state = ST_NORMAL;
            end
            ST_NORMAL: begin
                next_state = ST_NORMAL;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= ST_IDLE;
            load_cnt <= 6'd0;
            serial_boot_loader_mode <= 1'b0;
            normal_start <= 1'b0;
            ram_we <= 1'b0;
            ram_addr <= PC_RESET;
            ram_wdata <= SHIFT_RESET;
            run_start <= 1'b0;
            run_addr <= PC_RESET;
            fetch_base <= PC_RESET;
            tx_busy_d <= 1'b0;
        end else begin
            state <= next_state;
            load_cnt <= next_load_cnt;
            serial_boot_loader_mode <= next_mode;
            normal_start <= next_normal;
            ram_we <= next_we;
            ram_addr <= next_addr;
            ram_wdata <= next_wdata;
            run_start <= next_run;
            run_addr <= next_run_addr;
            fetch_base <= next_fetch;
            tx_busy_d <= tx_busy;
        end
    end

    // Identification byte transmitter
    bsld_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
        .mclk(mclk),
        .reset(reset),
        .start(tx_start),
        .data(ID_BYTE),
        .busy(tx_busy),
        .txd(txd)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Zero byte accepted while waiting for the host
    sequence s_zero_seen;
        state == ST_WAIT_ZERO && rx_vld && rx_sh == ZERO_BYTE;
    endsequence
    // Last byte of the window arrives
    sequence s_last_byte;
        state == ST_LOAD && rx_vld && load_cnt == 6'(LOAD_BYTES - 1);
    endsequence
    // It lands on the top address of the window
    sequence s_last_write;
        ram_we && ram_addr == RAM_WIN_END;
    endsequence
    // Execution then begins at the window start
    sequence s_run_go;
        run_start && run_addr == RAM_WIN_START && fetch_base == RAM_WIN_START;
    endsequence

    a_entry_low: assert property (@(posedge mclk) disable iff (reset) // see [RULE_01]
        state == ST_IDLE && reset_d && !sel_s2 |=> serial_boot_loader_mode)
        else $error("loader mode not entered with select low");
    a_entry_high: assert property (@(posedge mclk) disable iff (reset) // see [RULE_01]
        state == ST_IDLE && reset_d && sel_s2 |=> normal_start && !serial_boot_loader_mode)
        else $error("loader entered with select high");
    a_rom_fetch: assert property (@(posedge mclk) disable iff (reset) // see [RULE_03]
        serial_boot_loader_mode |-> fetch_base == BOOT_ROM_BASE)
        else $error("loader not fetching from boot rom");
    a_quiet_wait: assert property (@(posedge mclk) disable iff (reset) // see [RULE_04]
        state == ST_WAIT_ZERO |-> !ram_we && !tx_busy && txd)
        else $error("activity before zero byte");
    a_id_sent: assert property (@(posedge mclk) disable iff (reset) // see [RULE_05]
        s_zero_seen |-> ##2 tx_busy && !txd)
        else $error("id byte not started after zero");
    a_one_id: assert property (@(posedge mclk) disable iff (reset) // see [RULE_05]
        state == ST_LOAD |-> !tx_busy)
        else $error("second id byte");
    a_win_addr: assert property (@(posedge mclk) disable iff (reset) // see [RULE_06]
        ram_we |-> ram_addr >= RAM_WIN_START && ram_addr <= RAM_WIN_END)
        else $error("write outside load window");
    a_run_after: assert property (@(posedge mclk) disable iff (reset) // see [RULE_07]
        s_last_byte |=> s_last_write ##1 s_run_go)
        else $error("no run at window start after last byte");
endmodule // bsld_loader

// *** logic/bsl_pkg.sv ***
// Package of constants and types for the serial boot loader block
package bsld_pkg;
    // ------------------------------------------------------------
    // Clock and serial timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200000000;
    localparam int BAUD_DEFAULT = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
    localparam int DATA_BITS = 8;
    // ------------------------------------------------------------
    // Memory map of the load window and boot ROM
    // ------------------------------------------------------------
    localparam logic [15:0] RAM_WIN_START = 16'hfa40;
    localparam logic [15:0] RAM_WIN_END = 16'hfa5f;
    localparam int LOAD_BYTES = 32;
    localparam int FLASH_KBYTES = 128;
    localparam logic [15:0] BOOT_ROM_BASE = 16'h0000;
    // ------------------------------------------------------------
    // Reset values and the zero byte value
    // ------------------------------------------------------------
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Loader sequence states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_ZERO,
        ST_SEND_ID,
        ST_WAIT_ID,
        ST_LOAD,
        ST_RUN,
        ST_NORMAL
    } bsld_state_t;
endpackage

// *** logic/bsl_uart_tx.sv ***
// Serial transmitter: 8N1, least significant bit first
module bsld_uart_tx
    import bsld_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic start,
    input wire logic [7:0] data,
    output logic busy,
    output logic txd
);
    localparam int CW = $clog2(BIT_CYC + 1);
    logic [CW-1:0] cnt, next_cnt;
    logic [3:0] bitn, next_bitn;
    logic [9:0] frame, next_frame;
    logic next_busy, next_txd;

    // Frame is start, eight data bits, stop; shifted out LSB first
    always_comb begin
        next_cnt = cnt;
        next_bitn = bitn;
        next_frame = frame;
        next_busy = busy;
        next_txd = txd;
        if (!busy) begin
            next_txd = 1'b1;
            if (start) begin
                next_frame = {1'b1, data, 1'b0}; // see [RULE_10]
                next_busy = 1'b1;
                next_cnt = CW'(BIT_CYC - 1);
                next_bitn = 4'd0;
                next_txd = 1'b0;
            end
        end else if (cnt != '0) begin
            next_cnt = cnt - CW'(1);
        end else if (bitn == 4'd9) begin
            next_busy = 1'b0;
            next_txd = 1'b1;
        end else begin
            next_bitn = bitn + 4'd1;
            next_cnt = CW'(BIT_CYC - 1);
            next_txd = frame[bitn + 4'd1];
        end
    end

    // Registers only
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt <= '0;
            bitn <= 4'd0;
            frame <= 10'h3ff;
            busy <= 1'b0;
            txd <= 1'b1;
        end else begin
            cnt <= next_cnt;
            bitn <= next_bitn;
            frame <= next_frame;
            busy <= next_busy;
            txd <= next_txd;
        end
    end
endmodule // bsld_uart_tx

// *** sim/bsl_host.sv ***
// Host side model: serial download software on a PC port
module bsld_host #(
    parameter int BIT_CYC = 16
) (
    input wire logic mclk,
    input wire logic txd,
    output logic rxd,
    output logic [7:0] got_byte,
    output int got_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // Start, 8 data bits LSB first, stop; gap lets the host be slow
    task automatic send_byte(input logic [7:0] b, input int gap);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd = frame[i];
            repeat (BIT_CYC) @(negedge mclk);
        end
        repeat (gap) @(negedge mclk);
    endtask

    // Receiver samples mid-bit on the falling edge, clear of the launch edge
    // A bad stop bit discards the byte
    initial begin
        rxd = 1'b1;
        got_byte = 8'h00;
        got_count = 0;
        forever begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(negedge mclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(negedge mclk);
                got_byte[i] = txd;
            end
            repeat (BIT_CYC) @(negedge mclk);
            if (txd === 1'b1) begin
                got_count++;
            end
        end
    end
endmodule // bsld_host

// *** sim/bsl_loader_tb.sv ***
// Self-checking bench of the serial boot loader
module bsld_loader_tb
    import bsld_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 16;
    localparam logic [7:0] ID_VAL = 8'h6e; // Arbitrary identification value
    logic mclk, reset, boot_select_pin, rxd, txd, mode, normal_start;
    logic ram_we, run_start;
    logic [1:0] bus_config;
    logic [15:0] ram_addr, run_addr, fetch_base;
    logic [7:0] ram_wdata, got_byte;
    logic [15:0] wr_addr[$];
    logic [7:0] wr_data[$], exp_data[$];
    int got_count, n_run, n_fail, n_compared, cyc;

    bsld_loader #(.BIT_CYC(BC), .ID_BYTE(ID_VAL)) u_dut (.mclk(mclk), .reset(reset),
        .boot_select_pin(boot_select_pin), .bus_config(bus_config), .rxd(rxd), .txd(txd),
        .serial_boot_loader_mode(mode), .normal_start(normal_start), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .run_start(run_start),
        .run_addr(run_addr), .fetch_base(fetch_base));
    bsld_host #(.BIT_CYC(BC)) u_host (.mclk(mclk), .txd(txd), .rxd(rxd),
        .got_byte(got_byte), .got_count(got_count));

    // ------------------------------------------------------------
    // Clock, write monitor and hang guard
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Pre-edge values are the settled ones, so no race with the design
    always @(posedge mclk) begin
        cyc++;
        if (ram_we === 1'b1) begin
            wr_addr.push_back(ram_addr);
            wr_data.push_back(ram_wdata);
        end
        if (run_start === 1'b1) n_run++;
        if (cyc == 40000) begin
            n_fail++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_addr(input int n);
        return RAM_WIN_START + 16'(n);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strap stays stable through the whole reset pulse
    task automatic do_reset(input logic boot, input logic [1:0] cfg);
        @(negedge mclk);
        reset = 1'b1;
        boot_select_pin = boot;
        bus_config = cfg;
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        wr_addr.delete();
        wr_data.delete();
        n_run = 0;
    endtask
    task automatic wait_for(input int n);
        int k;
        k = 0;
        while (got_count < n && k < 400) begin
            @(negedge mclk);
            k++;
        end
    endtask
    task summarize();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] b;
        reset = 1'b1;
        boot_select_pin = 1'b1;
        bus_config = 2'h0;
        n_fail = 0;
        n_compared = 0;
        cyc = 0;
        n_run = 0;
        void'($urandom(46));
        // Strap high: normal start, a zero byte gets no answer
        do_reset(1'b1, 2'h0);
        check(16'(normal_start), 16'h0001);
        check(16'(mode), 16'h0000);
        u_host.send_byte(8'h00, 0);
        wait_for(1);
        check(16'(got_count), 16'h0000);
        // Strap low under every bus setting
        for (int c = 0; c < 4; c++) begin
            do_reset(1'b0, 2'(c));
            check(16'(mode), 16'h0001);
            check(16'(normal_start), 16'h0000);
            check(fetch_base, BOOT_ROM_BASE);
        end
        do_reset(1'b0, 2'($urandom_range(0, 3)));
        // Non-zero bytes must be ignored
        for (int i = 0; i < 3; i++) u_host.send_byte(8'($urandom_range(1, 255)), i);
        wait_for(1);
        check(16'(got_count), 16'h0000);
        check(16'(wr_addr.size()), 16'h0000);
        // Zero byte, then wait for the full ID before loading
        u_host.send_byte(ZERO_BYTE, 0);
        wait_for(1);
        check(16'(got_byte), 16'(ID_VAL));
        repeat (20 * BC) @(negedge mclk);
        check(16'(got_count), 16'h0001);
        // Load: edge values first and last, random between
        exp_data.delete();
        for (int i = 0; i < LOAD_BYTES; i++) begin
            b = (i == 0) ? 8'h00 : (i == LOAD_BYTES - 1) ? 8'hff : 8'($urandom());
            exp_data.push_back(b);
            if (i == LOAD_BYTES - 1) begin
                check(16'(n_run), 16'h0000);
                check(fetch_base, BOOT_ROM_BASE);
            end
            u_host.send_byte(b, $urandom_range(0, 3));
        end
        repeat (10) @(negedge mclk);
        check(16'(wr_addr.size()), 16'(LOAD_BYTES));
        for (int i = 0; i < wr_addr.size() && i < LOAD_BYTES; i++) begin
            check(wr_addr[i], exp_addr(i));
            check(16'(wr_data[i]), 16'(exp_data[i]));
        end
        check(16'(n_run), 16'h0001);
        check(run_addr, RAM_WIN_START);
        check(fetch_base, RAM_WIN_START);
        check(16'(mode), 16'h0000);
        // Bytes after the load are not stored
        u_host.send_byte(8'h00, 0);
        u_host.send_byte(8'($urandom()), 0);
        check(16'(wr_addr.size()), 16'(LOAD_BYTES));
        check(16'(n_run), 16'h0001);
        // Reset re-arms the loader
        do_reset(1'b0, 2'h3);
        check(16'(mode), 16'h0001);
        check(fetch_base, BOOT_ROM_BASE);
        summarize();
    end
endmodule // bsld_loader_tb
